// ===== rtl/hbp_dev.sv
// device end of the host bus port: cycle framing, decode, capture
// Operation
// R1 - read runs while select and read low
// R2 - write runs while select and write low
// R3 - latch read word at cycle start
// R4 - single reads reach registers and fifos
// R5 - host single read timing 45/32/13 ns
// R6 - host write timing 45/32/13 ns
// R7 - burst reads up to sixteen words
// R8 - address held 45 ns, data 40 ns
// R9 - host releases 13 ns between bursts
// R10 - steered read always hits receive fifo
// R11 - steered access keeps only A2..A1
// R12 - steered bursts have no length limit
// R13 - steered burst release lasts 13 ns
// R14 - steered write always fills transmit fifo
// R15 - steer input timed like an address line
// R16 - writes are single cycles only
// R17 - data bus is sixteen bits
// R18 - host waits 135 ns before fill info
// R19 - unsteered access decodes A7..A1
`default_nettype none
module hbp_dev (
  hbp_if.dev bus,
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic rd_req,
  output logic [hbp_pkg::ADDR_W-1:0] rd_addr,
  output logic rd_steer,
  input wire logic [hbp_pkg::DATA_W-1:0] rd_data,
  output logic wr_req,
  output logic [hbp_pkg::ADDR_W-1:0] wr_addr,
  output logic wr_steer,
  output logic [hbp_pkg::DATA_W-1:0] wr_data,
  output logic burst_over,
  output logic strobe_clash
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } hbp_dev_st_t;

  hbp_dev_st_t state_r;
  hbp_dev_st_t state_nxt;

  logic [hbp_pkg::PIN_W-1:0] pins_raw;
  logic [hbp_pkg::PIN_W-1:0] pins;

  logic [hbp_pkg::ADDR_W:0] key_r;
  logic rd_req_r;
  logic [hbp_pkg::ADDR_W-1:0] rd_addr_r;
  logic rd_steer_r;
  logic [hbp_pkg::DATA_W-1:0] dout_r;
  logic oe_r;
  logic [hbp_pkg::DATA_W-1:0] wdat_r;
  logic wr_req_r;
  logic [hbp_pkg::ADDR_W-1:0] wr_addr_r;
  logic wr_steer_r;
  logic [hbp_pkg::DATA_W-1:0] wr_data_r;
  logic [4:0] words_r;
  logic over_r;
  logic clash_r;

  // ==========================================================
  // pin capture
  // R17 sixteen-bit data
  assign pins_raw = {bus.select_low, bus.read_strobe_low,
                     bus.write_strobe_low, bus.fifo_steer,
                     bus.addr, bus.data_bus};

  hbp_sync #(
    .W(hbp_pkg::PIN_W),
    .INIT(hbp_pkg::DEV_PIN_INIT)
  ) u_pins (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(pins_raw),
    .dout(pins)
  );

  wire s_sel_low = pins[hbp_pkg::PIN_W-1];
  wire s_rd_low = pins[hbp_pkg::PIN_W-2];
  wire s_wr_low = pins[hbp_pkg::PIN_W-3];
  // R15 steer filtered like address
  wire s_steer = pins[hbp_pkg::PIN_W-4];
  wire [hbp_pkg::ADDR_W-1:0] s_addr =
    pins[hbp_pkg::DATA_W +: hbp_pkg::ADDR_W];
  wire [hbp_pkg::DATA_W-1:0] s_data = pins[hbp_pkg::DATA_W-1:0];

  // ==========================================================
  // cycle framing and decode
  // R1 read framing, any order
  wire rd_act = ~s_sel_low & ~s_rd_low;
  // R2 write framing, any order
  wire wr_act = ~s_sel_low & ~s_wr_low;
  wire clash = rd_act & wr_act;

  // R11 steered keeps A2..A1 only
  wire [hbp_pkg::ADDR_W-1:0] steer_addr =
    {{(hbp_pkg::ADDR_W - hbp_pkg::KEEP_W){1'b0}},
     s_addr[hbp_pkg::KEEP_W-1:0]};
  // R19 full decode when unsteered
  wire [hbp_pkg::ADDR_W-1:0] eff_addr = s_steer ? steer_addr : s_addr;
  wire [hbp_pkg::ADDR_W:0] key = {s_steer, eff_addr};
  wire key_moved = key != key_r;

  wire is_idle = state_r == ST_IDLE;
  wire is_read = state_r == ST_READ;
  wire is_write = state_r == ST_WRITE;
  // a read wins when both strobes are low, which is illegal anyway
  wire start_rd = is_idle & rd_act;
  wire start_wr = is_idle & wr_act & ~rd_act;
  // R7 burst word on address change
  wire next_word = is_read & rd_act & key_moved;
  // R4 single read reaches any target
  wire take = start_rd | next_word;
  wire end_wr = is_write & ~wr_act;
  // R12 steered burst never limited
  wire over_hit = next_word & ~s_steer &
                  (words_r == 5'(hbp_pkg::BURST_MAX));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (rd_act) begin
          state_nxt = ST_READ;
        end else if (wr_act) begin
          state_nxt = ST_WRITE;
        end
      end
      ST_READ: begin
        if (!rd_act) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WRITE: begin
        // R16 one word per write cycle
        if (!wr_act) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // R15 steer latched with address
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_r <= '0;
    end else if (take | start_wr) begin
      key_r <= key;
    end
  end

  // ==========================================================
  // read side
  // R10 steered read targets receive fifo
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_req_r <= 1'b0;
      rd_addr_r <= hbp_pkg::ADDR_INIT;
      rd_steer_r <= 1'b0;
    end else begin
      rd_req_r <= take;
      if (take) begin
        rd_addr_r <= eff_addr;
        rd_steer_r <= s_steer;
      end
    end
  end

  // R3 word frozen after request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_r <= hbp_pkg::DATA_INIT;
    end else if (rd_req_r) begin
      dout_r <= rd_data;
    end
  end

  // R8 drive new word per address
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= state_nxt == ST_READ;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      words_r <= '0;
      over_r <= 1'b0;
    end else begin
      over_r <= over_hit;
      if (start_rd) begin
        words_r <= 5'h01;
      end else if (next_word && words_r != 5'h1F) begin
        words_r <= words_r + 5'h01;
      end
    end
  end

  // ==========================================================
  // write side
  // last sample inside the cycle; data after release may be gone
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdat_r <= hbp_pkg::DATA_INIT;
    end else if (is_write && wr_act) begin
      wdat_r <= s_data;
    end
  end

  // R14 steered write targets transmit fifo
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_req_r <= 1'b0;
      wr_addr_r <= hbp_pkg::ADDR_INIT;
      wr_steer_r <= 1'b0;
      wr_data_r <= hbp_pkg::DATA_INIT;
    end else begin
      wr_req_r <= end_wr;
      if (end_wr) begin
        wr_addr_r <= key_r[hbp_pkg::ADDR_W-1:0];
        wr_steer_r <= key_r[hbp_pkg::ADDR_W];
        wr_data_r <= wdat_r;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clash_r <= 1'b0;
    end else begin
      clash_r <= clash;
    end
  end

  // ==========================================================
  // outputs
  assign bus.dev_dout = dout_r;
  assign bus.dev_oe = oe_r;
  assign rd_req = rd_req_r;
  assign rd_addr = rd_addr_r;
  assign rd_steer = rd_steer_r;
  assign wr_req = wr_req_r;
  assign wr_addr = wr_addr_r;
  assign wr_steer = wr_steer_r;
  assign wr_data = wr_data_r;
  assign burst_over = over_r;
  assign strobe_clash = clash_r;
endmodule
`default_nettype wire

// ===== rtl/hbp_host.sv
// host end of the host bus port: paces reads, bursts and writes
`default_nettype none
module hbp_host (
  hbp_if.host bus,
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_steer,
  input wire logic [hbp_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [3:0] cmd_len,
  input wire logic [hbp_pkg::DATA_W-1:0] cmd_wdata,
  output logic rsp_valid,
  output logic [hbp_pkg::DATA_W-1:0] rsp_data
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_READ = 2'b01,
    HS_WRITE = 2'b10,
    HS_GAP = 2'b11
  } hbp_host_st_t;

  localparam logic [hbp_pkg::CNT_W-1:0] RD_LOAD =
    hbp_pkg::CNT_W'(hbp_pkg::RD_WAIT_CYC - 1);
  localparam logic [hbp_pkg::CNT_W-1:0] WR_LOAD =
    hbp_pkg::CNT_W'(hbp_pkg::WR_ACT_CYC - 1);
  localparam logic [hbp_pkg::CNT_W-1:0] GAP_LOAD =
    hbp_pkg::CNT_W'(hbp_pkg::GAP_CYC - 1);
  localparam logic [hbp_pkg::CNT_W-1:0] RAR_LOAD =
    hbp_pkg::CNT_W'(hbp_pkg::RAR_CYC);
  // a new command can start two edges after the gap count runs out
  localparam logic [hbp_pkg::CNT_W-1:0] TURN_LOAD =
    hbp_pkg::CNT_W'(hbp_pkg::TURN_CYC - 2);
  localparam logic [hbp_pkg::CNT_W-1:0] CNT_STEP = hbp_pkg::CNT_W'(1);

  hbp_host_st_t state_r;
  logic sel_r;
  logic rd_r;
  logic wr_r;
  logic [hbp_pkg::ADDR_W-1:0] addr_r;
  logic steer_r;
  logic [hbp_pkg::DATA_W-1:0] dout_r;
  logic oe_r;
  logic [hbp_pkg::CNT_W-1:0] cnt_r;
  logic [hbp_pkg::CNT_W-1:0] rar_r;
  logic [3:0] words_r;
  logic ready_r;
  logic rsp_valid_r;
  logic [hbp_pkg::DATA_W-1:0] rsp_data_r;
  logic [hbp_pkg::DATA_W-1:0] s_data;

  hbp_sync #(
    .W(hbp_pkg::DATA_W),
    .INIT(hbp_pkg::DATA_INIT)
  ) u_data (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(bus.data_bus),
    .dout(s_data)
  );

  // ==========================================================
  // pacing
  wire cnt_done = cnt_r == '0;
  wire rar_clear = rar_r == '0;
  // R18 hold reads off after fifo read
  wire accept = ready_r & cmd_valid & (cmd_write | rar_clear);
  wire last_word = words_r == 4'h0;

  // R1 R2 R5 R6 R7 R8 R9 R13 R16 strobe pacing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= HS_IDLE;
      sel_r <= 1'b1;
      rd_r <= 1'b1;
      wr_r <= 1'b1;
      addr_r <= hbp_pkg::ADDR_INIT;
      steer_r <= 1'b0;
      dout_r <= hbp_pkg::DATA_INIT;
      oe_r <= 1'b0;
      cnt_r <= '0;
      words_r <= '0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= hbp_pkg::DATA_INIT;
    end else begin
      rsp_valid_r <= 1'b0;
      unique case (state_r)
        HS_IDLE: begin
          if (accept) begin
            addr_r <= cmd_addr;
            steer_r <= cmd_steer;
            sel_r <= 1'b0;
            if (cmd_write) begin
              state_r <= HS_WRITE;
              wr_r <= 1'b0;
              dout_r <= cmd_wdata;
              oe_r <= 1'b1;
              cnt_r <= WR_LOAD;
            end else begin
              state_r <= HS_READ;
              rd_r <= 1'b0;
              words_r <= cmd_len;
              cnt_r <= RD_LOAD;
            end
          end
        end
        HS_READ: begin
          if (!cnt_done) begin
            cnt_r <= cnt_r - CNT_STEP;
          end else begin
            rsp_valid_r <= 1'b1;
            rsp_data_r <= s_data;
            if (last_word) begin
              state_r <= HS_GAP;
              sel_r <= 1'b1;
              rd_r <= 1'b1;
              // device still drives until its filter sees the release
              cnt_r <= TURN_LOAD;
            end else begin
              addr_r <= addr_r + 7'h01;
              words_r <= words_r - 4'h1;
              cnt_r <= RD_LOAD;
            end
          end
        end
        HS_WRITE: begin
          if (!cnt_done) begin
            cnt_r <= cnt_r - CNT_STEP;
          end else begin
            state_r <= HS_GAP;
            sel_r <= 1'b1;
            wr_r <= 1'b1;
            oe_r <= 1'b0;
            cnt_r <= GAP_LOAD;
          end
        end
        HS_GAP: begin
          if (!cnt_done) begin
            cnt_r <= cnt_r - CNT_STEP;
          end else begin
            state_r <= HS_IDLE;
          end
        end
      endcase
    end
  end

  // R18 wait counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rar_r <= '0;
    end else if (state_r == HS_READ && cnt_done && last_word && steer_r) begin
      rar_r <= RAR_LOAD;
    end else if (!rar_clear) begin
      rar_r <= rar_r - CNT_STEP;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (state_r == HS_IDLE && !accept) ||
                 (state_r == HS_GAP && cnt_done);
    end
  end

  // ==========================================================
  // outputs
  assign bus.select_low = sel_r;
  assign bus.read_strobe_low = rd_r;
  assign bus.write_strobe_low = wr_r;
  assign bus.addr = addr_r;
  assign bus.fifo_steer = steer_r;
  assign bus.host_dout = dout_r;
  assign bus.host_oe = oe_r;
  assign cmd_ready = ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
endmodule
`default_nettype wire

// ===== rtl/hbp_if.sv
// pin bundle between host and device, with the data bus resolved
`default_nettype none
interface hbp_if;
  logic select_low;
  logic read_strobe_low;
  logic write_strobe_low;
  logic [hbp_pkg::ADDR_W-1:0] addr;
  logic fifo_steer;
  logic [hbp_pkg::DATA_W-1:0] host_dout;
  logic host_oe;
  logic [hbp_pkg::DATA_W-1:0] dev_dout;
  logic dev_oe;
  logic [hbp_pkg::DATA_W-1:0] data_bus;

  // ==========================================================
  // bus level: device wins a clash, pull-up when nobody drives
  assign data_bus = dev_oe ? dev_dout :
                    host_oe ? host_dout : hbp_pkg::BUS_IDLE;

  modport dev (
    input select_low,
    input read_strobe_low,
    input write_strobe_low,
    input addr,
    input fifo_steer,
    input data_bus,
    output dev_dout,
    output dev_oe
  );

  modport host (
    output select_low,
    output read_strobe_low,
    output write_strobe_low,
    output addr,
    output fifo_steer,
    output host_dout,
    output host_oe,
    input data_bus
  );
endinterface
`default_nettype wire

// ===== rtl/hbp_pkg.sv
// shared constants for the host bus port, both ends
`default_nettype none
package hbp_pkg;
  // ==========================================================
  // widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;
  localparam int KEEP_W = 2;
  localparam int BURST_MAX = 16;
  localparam int PIN_W = 3 + 1 + ADDR_W + DATA_W;
  localparam int CNT_W = 5;

  // ==========================================================
  // reset values
  localparam logic [PIN_W-1:0] DEV_PIN_INIT = 27'h7000000;
  localparam logic [DATA_W-1:0] DATA_INIT = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_INIT = 7'h00;
  localparam logic [DATA_W-1:0] BUS_IDLE = 16'hFFFF;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_CYCLE_NS = 45;
  localparam int T_ASSERT_NS = 32;
  localparam int T_DEASSERT_NS = 13;
  localparam int T_ACYC_NS = 45;
  localparam int T_ADV_NS = 40;
  localparam int T_RAR_NS = 135;
  localparam int T_CYCLE_CYC =
    (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ASSERT_CYC =
    (T_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEASSERT_CYC =
    (T_DEASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACYC_CYC = (T_ACYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADV_CYC = T_ADV_NS / CLK_PERIOD_NS;
  localparam int RAR_CYC = (T_RAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // pin filters need two agreeing samples, one cycle more each phase
  localparam int WR_ACT_CYC = ASSERT_CYC + 1;
  localparam int GAP_CYC = DEASSERT_CYC + 1;
  // covers both pin filters and the device capture pipeline
  localparam int RD_WAIT_CYC = 12;
  // device drops its data drive five edges after the strobes rise
  localparam int TURN_CYC = 5;
endpackage
`default_nettype wire

// ===== rtl/hbp_sync.sv
// three-stage pin synchroniser with agreement filter per bit
`default_nettype none
module hbp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;

  // ==========================================================
  // per-bit chain; stage one feeds stage two only
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[i] <= INIT[i];
          s2_r[i] <= INIT[i];
          s3_r[i] <= INIT[i];
          out_r[i] <= INIT[i];
        end else begin
          s1_r[i] <= din[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            out_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  assign dout = out_r;
endmodule
`default_nettype wire

// ===== tb/async_host_bus_read_write_port_tb.sv
// testbench: host and device ends joined, commands in, words checked
`default_nettype none
module async_host_bus_read_write_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_steer = 1'b0;
  logic [hbp_pkg::ADDR_W-1:0] cmd_addr = '0;
  logic [3:0] cmd_len = 4'h0;
  logic [hbp_pkg::DATA_W-1:0] cmd_wdata = '0;
  logic cmd_ready, rsp_valid, rd_req, rd_steer, wr_req, wr_steer;
  logic burst_over, strobe_clash, bad_rd, bad_over, bad_clash;
  logic [15:0] over_hits = 16'h0000;
  logic clash_seen = 1'b0;
  logic [hbp_pkg::DATA_W-1:0] rsp_data, rd_data, wr_data;
  logic [hbp_pkg::ADDR_W-1:0] rd_addr, wr_addr;
  logic [15:0] bad_hits = 16'h0000;
  int failures = 0;
  int checks_done = 0;
  int hi_cnt = 0;
  logic last_st = 1'b0;

  hbp_if bus_if ();
  hbp_if bad_if ();
  hbp_host hbp_host_i (.bus(bus_if), .sys_clk(sys_clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_steer(cmd_steer), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  hbp_dev hbp_dev_i (.bus(bus_if), .sys_clk(sys_clk), .rst_n(rst_n),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_steer(rd_steer),
    .rd_data(rd_data), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_steer(wr_steer), .wr_data(wr_data), .burst_over(burst_over),
    .strobe_clash(strobe_clash));
  // second device faced by a rule-breaking driver
  hbp_dev hbp_dev_bad_i (.bus(bad_if), .sys_clk(sys_clk), .rst_n(rst_n),
    .rd_req(bad_rd), .rd_addr(), .rd_steer(), .rd_data(16'h0000),
    .wr_req(), .wr_addr(), .wr_steer(), .wr_data(), .burst_over(bad_over),
    .strobe_clash(bad_clash));
  hbp_properties hbp_properties_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .select_low(bus_if.select_low), .read_strobe_low(bus_if.read_strobe_low),
    .write_strobe_low(bus_if.write_strobe_low), .addr(bus_if.addr),
    .fifo_steer(bus_if.fifo_steer), .host_dout(bus_if.host_dout),
    .host_oe(bus_if.host_oe), .dev_oe(bus_if.dev_oe));

  // read source shows which port was decoded
  assign rd_data = {rd_steer, 8'h00, rd_addr};

  always #(hbp_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  // ==========================================================
  // checking and closing
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(negedge sys_clk) begin
    if (rst_n && (burst_over !== 1'b0 || strobe_clash !== 1'b0)) begin
      failures++;
      $display("ERROR %0t unexpected device flag", $time);
    end
    if (bad_rd === 1'b1) begin
      bad_hits++;
    end
    if (bad_over === 1'b1) begin
      over_hits++;
    end
    if (bad_clash === 1'b1) begin
      clash_seen = 1'b1;
    end
    if (bus_if.read_strobe_low === 1'b0) begin
      if (hi_cnt > 0 && last_st) begin
        check({15'h0000, hi_cnt < hbp_pkg::RAR_CYC}, 16'h0000,
              "rar gap");
      end
      hi_cnt = 0;
      last_st = bus_if.fifo_steer;
    end else begin
      hi_cnt++;
    end
  end

  // ==========================================================
  // one host command, then its words checked
  task automatic xfer(input logic wr, input logic st,
                      input logic [hbp_pkg::ADDR_W-1:0] a,
                      input logic [3:0] len, input logic [15:0] wd);
    int n;
    logic [hbp_pkg::ADDR_W-1:0] ai;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_steer <= st;
    cmd_addr <= a;
    cmd_len <= len;
    cmd_wdata <= wd;
    // ready stays up while a steered read wait runs, so hold valid
    do begin
      @(negedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b0 && n < 200);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    for (int i = 0; i <= (wr ? 0 : int'(len)); i++) begin
      n = 0;
      ai = a + i[hbp_pkg::ADDR_W-1:0];
      do begin
        @(negedge sys_clk);
        n++;
      end while ((wr ? wr_req : rsp_valid) !== 1'b1 && n < 40);
      if (wr) begin
        check(wr_data, wd, "write data");
        check({8'h00, wr_steer, wr_addr},
              {8'h00, st, st ? {5'h00, a[1:0]} : a}, "write port");
      end else begin
        check(rsp_data, {st, 8'h00, st ? {5'h00, ai[1:0]} : ai},
              "read");
      end
    end
  endtask

  initial begin
    bad_if.select_low = 1'b1;
    bad_if.read_strobe_low = 1'b1;
    bad_if.write_strobe_low = 1'b1;
    bad_if.addr = '0;
    bad_if.fifo_steer = 1'b0;
    bad_if.host_dout = '0;
    bad_if.host_oe = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    xfer(1'b0, 1'b0, 7'h00, 4'h0, 16'h0000);
    xfer(1'b0, 1'b0, 7'h7F, 4'h0, 16'h0000);
    xfer(1'b0, 1'b1, 7'h7E, 4'h0, 16'h0000);
    xfer(1'b0, 1'b0, 7'h55, 4'h0, 16'h0000);
    xfer(1'b0, 1'b0, 7'h78, 4'hF, 16'h0000);
    xfer(1'b0, 1'b1, 7'h3C, 4'hF, 16'h0000);
    xfer(1'b1, 1'b0, 7'h2A, 4'h0, 16'hA55A);
    xfer(1'b1, 1'b0, 7'h7F, 4'h0, 16'hFFFF);
    xfer(1'b1, 1'b1, 7'h7C, 4'h0, 16'h1234);
    xfer(1'b0, 1'b1, 7'h05, 4'h2, 16'h0000);
    // one-cycle strobe must be filtered, a full one taken once
    @(posedge sys_clk);
    bad_if.select_low <= 1'b0;
    bad_if.read_strobe_low <= 1'b0;
    @(posedge sys_clk);
    bad_if.select_low <= 1'b1;
    bad_if.read_strobe_low <= 1'b1;
    repeat (12) @(posedge sys_clk);
    check(bad_hits, 16'h0000, "short strobe taken");
    bad_if.select_low <= 1'b0;
    bad_if.read_strobe_low <= 1'b0;
    repeat (3) @(posedge sys_clk);
    bad_if.select_low <= 1'b1;
    bad_if.read_strobe_low <= 1'b1;
    repeat (12) @(posedge sys_clk);
    check(bad_hits, 16'h0001, "full strobe count");
    // seventeen plain words flag once; a steered burst runs on
    for (int s = 0; s < 2; s++) begin
      bad_if.fifo_steer <= s[0];
      bad_if.select_low <= 1'b0;
      bad_if.read_strobe_low <= 1'b0;
      for (int k = 1; k <= hbp_pkg::BURST_MAX; k++) begin
        repeat (3) @(posedge sys_clk);
        bad_if.addr <= k[hbp_pkg::ADDR_W-1:0];
      end
      repeat (3) @(posedge sys_clk);
      bad_if.select_low <= 1'b1;
      bad_if.read_strobe_low <= 1'b1;
      repeat (6) @(posedge sys_clk);
      bad_if.addr <= '0;
    end
    // all three strobes low: read wins, clash flagged
    bad_if.select_low <= 1'b0;
    bad_if.read_strobe_low <= 1'b0;
    bad_if.write_strobe_low <= 1'b0;
    repeat (3) @(posedge sys_clk);
    bad_if.select_low <= 1'b1;
    bad_if.read_strobe_low <= 1'b1;
    bad_if.write_strobe_low <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check(over_hits, 16'h0001, "burst over count");
    check({15'h0000, clash_seen}, 16'h0001, "strobe clash");
    summarize();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire

// ===== tb/hbp_properties.sv
// pin-level checker for the host bus port, host and device ends
`default_nettype none
module hbp_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic select_low,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic [hbp_pkg::ADDR_W-1:0] addr,
  input wire logic fifo_steer,
  input wire logic [hbp_pkg::DATA_W-1:0] host_dout,
  input wire logic host_oe,
  input wire logic dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire logic rd_on = !select_low && !read_strobe_low;
  wire logic wr_on = !select_low && !write_strobe_low;

  // ==========================================================
  // framing
  bus_one_driver_a: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the data bus");
  read_start_a: assert property ($rose(dev_oe) |-> rd_on)
    else $error("device drives outside a read cycle");
  read_end_a: assert property (rd_on ##1 !rd_on |-> ##[1:8] !dev_oe)
    else $error("device keeps driving after read end");
  read_answer_a: assert property (
    $fell(read_strobe_low) && !select_low |-> ##[1:8] dev_oe)
    else $error("no read data driven in time");
  host_drive_a: assert property (host_oe |-> wr_on)
    else $error("host drives data outside a write");
  no_mixed_a: assert property (!(rd_on && !write_strobe_low))
    else $error("read and write strobes low together");

  // ==========================================================
  // host pacing, two cycles cover 32 ns and 13 ns
  write_width_a: assert property (
    $fell(write_strobe_low) |-> wr_on[*2])
    else $error("write strobe too short");
  read_width_a: assert property ($fell(read_strobe_low) |-> rd_on[*2])
    else $error("read strobe too short");
  release_gap_a: assert property ($rose(select_low) |-> select_low[*2])
    else $error("select released too briefly");
  steer_gap_a: assert property (
    $rose(read_strobe_low) && fifo_steer |-> read_strobe_low[*2])
    else $error("steered read released too briefly");
  single_write_a: assert property (
    $fell(write_strobe_low) |-> ##[2:6] write_strobe_low)
    else $error("write cycle does not end");
  write_hold_a: assert property (
    !write_strobe_low && $past(!write_strobe_low) |->
    $stable(addr) && $stable(fifo_steer) && $stable(host_dout))
    else $error("address or data moved during write");
  addr_hold_a: assert property (
    rd_on && $changed(addr) |-> ##1 (rd_on && $stable(addr))[*2])
    else $error("burst address held too briefly");
endmodule
`default_nettype wire
